// ==== verilog/resolver_feedback_top.sv ====
// Resolver feedback setup, trip logic and simulated encoder output.
// Assumes position and speed come from converter logic on CLK; the
// wire-fault pin is asynchronous.
`timescale 1ns/100ps
`default_nettype none

module resolver_feedback_top #(
	parameter logic [7:0] SLOT_MENU = 8'h0f, // Menu holding the position.
	parameter int STEP_CYCLES = resolver_pkg::EDGE_CYCLES
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [15:0] POS_IN,
	input wire logic [15:0] SRC_VALUE,
	output logic [15:0] SRC_ID,
	input wire logic [19:0] SPEED_MAG,
	input wire logic WIRE_FAULT,
	output logic EXC_HIGH,
	output logic TRIP,
	output logic QUAD_A,
	output logic QUAD_B,
	output logic IRQ
);
	// ------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------
	logic [5:0] cfg_reg; // Ratio, lines, poles, wire-break enable.
	logic [15:0] src_reg; // Selected source, menu high byte.
	logic [15:0] numer_reg; // Numerator in 1e-4 units.
	logic [2:0] status_reg; // Sticky events.
	logic [2:0] enable_reg; // Interrupt enables.
	logic ack_reg; // Answer cycle of a bus request.
	logic [31:0] rdata_reg; // Read data, stable at the answer.
	logic fault_s1_reg; // Synchroniser first stage.
	logic fault_s2_reg; // Synchroniser second stage.
	logic over_reg; // Previous overspeed level.
	logic [2:0] status_next;

	// ------------------------------------------------------------
	// Bus decode.
	// ------------------------------------------------------------
	wire req_w;
	wire wr_w;
	wire wr_cfg_w;
	wire wr_src_w;
	wire wr_num_w;
	wire wr_clr_w;
	wire wr_en_w;
	wire [1:0] wlines_w;
	wire cfg_ok_w;
	wire src_ok_w;
	wire num_ok_w;
	wire reject_w;

	assign req_w = AVS_READ || AVS_WRITE;
	// A write lands only on the cycle with waitrequest low.
	assign wr_w = AVS_WRITE && ack_reg;
	assign wr_cfg_w = wr_w && AVS_ADDRESS == resolver_pkg::ADDR_CONFIG;
	assign wr_src_w = wr_w && AVS_ADDRESS == resolver_pkg::ADDR_SOURCE;
	assign wr_num_w = wr_w && AVS_ADDRESS == resolver_pkg::ADDR_NUMER;
	assign wr_clr_w = wr_w && AVS_ADDRESS == resolver_pkg::ADDR_CLEAR;
	assign wr_en_w = wr_w && AVS_ADDRESS == resolver_pkg::ADDR_ENABLE;

	// Only three lines settings exist; every two-bit pole code is legal.
	assign wlines_w = AVS_WRITEDATA[resolver_pkg::CFG_LINES_LO +: 2];
	assign cfg_ok_w = wlines_w != resolver_pkg::LINES_ILLEGAL;
	// Identifier must not pass 21.51.
	assign src_ok_w = AVS_WRITEDATA[15:8] < resolver_pkg::SRC_MENU_MAX ?
		AVS_WRITEDATA[7:0] <= resolver_pkg::SRC_PARAM_MAX :
		AVS_WRITEDATA[15:8] == resolver_pkg::SRC_MENU_MAX &&
		AVS_WRITEDATA[7:0] <= resolver_pkg::SRC_LAST_PARAM;
	assign num_ok_w = AVS_WRITEDATA[15:0] <= resolver_pkg::NUMER_MAX;
	assign reject_w = (wr_cfg_w && !cfg_ok_w) || (wr_src_w && !src_ok_w) ||
		(wr_num_w && !num_ok_w);

	// ------------------------------------------------------------
	// Derived operating values.
	// ------------------------------------------------------------
	wire [1:0] lines_w;
	wire [1:0] poles_w;
	wire [3:0] cycles_w;
	wire [19:0] limit_w;
	wire over_w;
	wire fault_w;
	wire [2:0] event_w;
	wire pos_sel_w;
	wire [15:0] src_val_w;

	assign lines_w = cfg_reg[resolver_pkg::CFG_LINES_LO +: 2];
	assign poles_w = cfg_reg[resolver_pkg::CFG_POLES_LO +: 2];
	// Pole code n means 2n+2 poles, so cycles per rev are n+1.
	assign cycles_w = {2'b00, poles_w} + 4'h1;
	assign limit_w = resolver_pkg::SPEED_TABLE[{poles_w, lines_w}];
	assign over_w = SPEED_MAG > limit_w;
	// Checking is off entirely while detection is disabled.
	assign fault_w = fault_s2_reg &&
		cfg_reg[resolver_pkg::CFG_WBRK_EN];
	assign event_w = {reject_w, over_w && !over_reg, fault_w};
	// The own position counter feeds the output unless another is chosen.
	assign pos_sel_w = src_reg ==
		{SLOT_MENU, resolver_pkg::SRC_POS_PARAM};
	assign src_val_w = pos_sel_w ? POS_IN : SRC_VALUE;

	// Events set over a clear in the same cycle.
	always_comb begin
		status_next = status_reg;
		if (wr_clr_w) begin
			status_next = status_reg & ~AVS_WRITEDATA[2:0];
		end
		status_next = status_next | event_w;
	end

	// ------------------------------------------------------------
	// Read mux.
	// ------------------------------------------------------------
	wire [31:0] rmux_w;

	quad_target_if tgt_if ();

	assign rmux_w =
		AVS_ADDRESS == resolver_pkg::ADDR_CONFIG ? {26'h0, cfg_reg} :
		AVS_ADDRESS == resolver_pkg::ADDR_SOURCE ? {16'h0, src_reg} :
		AVS_ADDRESS == resolver_pkg::ADDR_NUMER ? {16'h0, numer_reg} :
		AVS_ADDRESS == resolver_pkg::ADDR_STATUS ? {29'h0, status_reg} :
		AVS_ADDRESS == resolver_pkg::ADDR_ENABLE ? {29'h0, enable_reg} :
		AVS_ADDRESS == resolver_pkg::ADDR_INFO ?
		{17'h0, tgt_if.shift, cycles_w, 4'h0, tgt_if.res_bits} :
		AVS_ADDRESS == resolver_pkg::ADDR_LIMIT ? {12'h0, limit_w} :
		32'h0000_0000;

	// Bus handshake: every request is answered on its second cycle.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req_w && !ack_reg;
			rdata_reg <= rmux_w;
		end
	end

	// Setup registers keep their value when a write is refused.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cfg_reg <= resolver_pkg::CFG_RESET;
			src_reg <= {SLOT_MENU, resolver_pkg::SRC_POS_PARAM};
			numer_reg <= resolver_pkg::NUMER_ONE;
			enable_reg <= 3'h0;
		end else begin
			if (wr_cfg_w && cfg_ok_w) begin
				cfg_reg <= AVS_WRITEDATA[5:0];
			end
			if (wr_src_w && src_ok_w) begin
				src_reg <= AVS_WRITEDATA[15:0];
			end
			if (wr_num_w && num_ok_w) begin
				numer_reg <= AVS_WRITEDATA[15:0];
			end
			if (wr_en_w) begin
				enable_reg <= AVS_WRITEDATA[2:0];
			end
		end
	end

	// Fault pin synchroniser, overspeed edge and sticky status.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			fault_s1_reg <= 1'b0;
			fault_s2_reg <= 1'b0;
			over_reg <= 1'b0;
			status_reg <= 3'h0;
		end else begin
			fault_s1_reg <= WIRE_FAULT;
			fault_s2_reg <= fault_s1_reg;
			over_reg <= over_w;
			status_reg <= status_next;
		end
	end

	// ------------------------------------------------------------
	// Simulated encoder output.
	// ------------------------------------------------------------
	sim_scaler u_scaler (
		.clk(CLK),
		.srst(SRST),
		.src(src_val_w),
		.numer(numer_reg),
		.lines(lines_w),
		.tgt(tgt_if.producer)
	);

	quad_output #(.STEP_CYCLES(STEP_CYCLES)) u_quad (
		.clk(CLK),
		.srst(SRST),
		.tgt(tgt_if.consumer),
		.phase_a(QUAD_A),
		.phase_b(QUAD_B)
	);

	// ------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------
	assign AVS_WAITREQUEST = !ack_reg;
	assign AVS_READDATA = rdata_reg;
	assign SRC_ID = src_reg;
	// Higher drive for the larger 3:1 ratio.
	assign EXC_HIGH = !cfg_reg[resolver_pkg::CFG_RATIO];
	assign TRIP = status_reg[resolver_pkg::ST_TRIP];
	assign IRQ = |(status_reg & enable_reg);

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	a_trip_gated: assert property (
		@(posedge CLK) disable iff (SRST)
		(fault_s2_reg && cfg_reg[resolver_pkg::CFG_WBRK_EN]) |=> TRIP)
		else $error("Enabled wire fault did not trip.");
	a_trip_off: assert property (
		@(posedge CLK) disable iff (SRST)
		(!TRIP && !cfg_reg[resolver_pkg::CFG_WBRK_EN]) |=> !TRIP)
		else $error("Trip raised with detection disabled.");
	a_lines_legal: assert property (
		@(posedge CLK) disable iff (SRST)
		lines_w != resolver_pkg::LINES_ILLEGAL)
		else $error("Illegal lines code stored.");
	// The scaler copy is one register behind the setup, and it still holds
	// its reset value on the first edge after reset is released.
	a_res_bits: assert property (
		@(posedge CLK) disable iff (SRST)
		!$past(SRST) |-> tgt_if.res_bits ==
		resolver_pkg::RES_BASE + {1'b0, $past(lines_w), 1'b0})
		else $error("Resolution does not follow lines.");
	a_src_range: assert property (
		@(posedge CLK) disable iff (SRST)
		src_reg[15:8] <= resolver_pkg::SRC_MENU_MAX)
		else $error("Source identifier beyond range.");
	a_excite_follow: assert property (
		@(posedge CLK) disable iff (SRST)
		(wr_cfg_w && cfg_ok_w) |=>
		EXC_HIGH == !$past(AVS_WRITEDATA[resolver_pkg::CFG_RATIO]))
		else $error("Excitation did not follow ratio.");
	a_reject_keeps: assert property (
		@(posedge CLK) disable iff (SRST)
		(wr_cfg_w && !cfg_ok_w) |=> $stable(cfg_reg) &&
		status_reg[resolver_pkg::ST_REJECT])
		else $error("Refused setting was stored.");
	// A new overspeed is flagged on the next edge, even against a clear.
	a_overspd_flag: assert property (
		@(posedge CLK) disable iff (SRST)
		(over_w && !over_reg) |=> status_reg[resolver_pkg::ST_OVERSPD])
		else $error("Overspeed was not flagged.");
	// A trip stays set until software writes a clear.
	a_trip_sticky: assert property (
		@(posedge CLK) disable iff (SRST)
		(TRIP && !wr_clr_w) |=> TRIP)
		else $error("Trip dropped without a clear.");
	a_irq_level: assert property (@(posedge CLK) disable iff (SRST)
		IRQ == |(status_reg & enable_reg))
		else $error("Interrupt disagrees with status.");
endmodule

`default_nettype wire

// ==== verilog/resolver_pkg.sv ====
// Shared constants for the resolver feedback and simulated encoder block.
// Assumes a single 200 MHz clock and Avalon-MM byte addressing.
//
// Contract
// - Excitation level follows 3:1 or 2:1 ratio.
// - Equivalent lines only 256, 1024 or 4096.
// - Resolution is 14, 12 or 10 bits.
// - Speed ceiling from lines and pole count.
// - Simulated output gives four counts per line.
// - Electrical cycles equal poles divided by two.
// - Pole count only 2, 4, 6 or 8.
// - Enabled wire-break detection trips; default enabled.
// - Source defaults to resolver position counter.
// - Source identifier limited to 00.00 through 21.51.
// - Output is source times numerator, default unity.
// - 14-bit scale quantised to powers of two.
// - 12-bit scale at least 1/8; 10-bit 1/2.
// - Numerator 0.5001 to 3.0000 gives unity scale.

package resolver_pkg;

	// ------------------------------------------------------------
	// Register byte offsets.
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_CONFIG = 6'h00; // Setup fields.
	localparam logic [5:0] ADDR_SOURCE = 6'h04; // Source identifier.
	localparam logic [5:0] ADDR_NUMER = 6'h08; // Numerator, 1e-4 units.
	localparam logic [5:0] ADDR_STATUS = 6'h0c; // Sticky events, read only.
	localparam logic [5:0] ADDR_CLEAR = 6'h10; // Write one to clear.
	localparam logic [5:0] ADDR_ENABLE = 6'h14; // Interrupt enables.
	localparam logic [5:0] ADDR_INFO = 6'h18; // Derived operating values.
	localparam logic [5:0] ADDR_LIMIT = 6'h1c; // Speed ceiling, 0.1 units.

	// ------------------------------------------------------------
	// Configuration field positions and reset values.
	// ------------------------------------------------------------
	localparam int CFG_RATIO = 0; // 0 selects 3:1, 1 selects 2:1.
	localparam int CFG_LINES_LO = 1; // Two bits of lines code.
	localparam int CFG_POLES_LO = 3; // Two bits of pole code.
	localparam int CFG_WBRK_EN = 5; // Wire-break detection enable.
	localparam logic [5:0] CFG_RESET = 6'h24; // 4096 lines, 2 poles, on.
	localparam logic [1:0] LINES_ILLEGAL = 2'h3; // Unused lines code.

	// Status bit positions.
	localparam int ST_TRIP = 0; // Broken feedback wire seen.
	localparam int ST_OVERSPD = 1; // Speed rose above ceiling.
	localparam int ST_REJECT = 2; // Illegal setting refused.
	localparam int ST_WIDTH = 3;

	// ------------------------------------------------------------
	// Source and numerator limits.
	// ------------------------------------------------------------
	localparam logic [7:0] SRC_MENU_MAX = 8'h15; // Menu 21.
	localparam logic [7:0] SRC_PARAM_MAX = 8'h63; // Parameter 99.
	localparam logic [7:0] SRC_LAST_PARAM = 8'h33; // 21.51 is last.
	localparam logic [7:0] SRC_POS_PARAM = 8'h05; // Position, x.05.
	localparam logic [15:0] NUMER_ONE = 16'h2710; // 1.0000.
	localparam logic [15:0] NUMER_MAX = 16'h7530; // 3.0000.
	localparam logic [15:0] NUMER_T32 = 16'h0138; // 0.0312.
	localparam logic [15:0] NUMER_T16 = 16'h0271; // 0.0625.
	localparam logic [15:0] NUMER_T8 = 16'h04e2; // 0.1250.
	localparam logic [15:0] NUMER_T4 = 16'h09c4; // 0.2500.
	localparam logic [15:0] NUMER_T2 = 16'h1388; // 0.5000.

	// ------------------------------------------------------------
	// Resolution and timing.
	// ------------------------------------------------------------
	localparam logic [3:0] RES_BASE = 4'ha; // Bits at the 256 setting.
	localparam logic [4:0] POS_BITS = 5'h10; // Width of rollover source.
	localparam logic [2:0] QUAD_COUNTS = 3'h4; // Counts per line.
	localparam int EDGE_MIN_NS = 100; // Least time between edges.
	localparam int CLK_NS = 5; // Clock period.
	localparam int EDGE_CYCLES = (EDGE_MIN_NS + CLK_NS - 1) / CLK_NS;

	// Speed ceilings in 0.1 units, indexed by {pole code, lines code}.
	localparam logic [19:0] SPEED_TABLE [0:15] = '{
		20'h61a80, 20'h203a0, 20'h080e8, 20'h00000,
		20'h40740, 20'h101d0, 20'h04074, 20'h00000,
		20'h2af80, 20'h0abe0, 20'h02af8, 20'h00000,
		20'h203a0, 20'h080e8, 20'h0203a, 20'h00000
	};

endpackage

// ==== verilog/quad_target_if.sv ====
// Carries the scaled count target from the scaler to the encoder output.
// Assumes both ends share CLK.
`timescale 1ns/100ps
`default_nettype none

interface quad_target_if;
	logic [15:0] target; // Desired count, shifted down to the resolution.
	logic [3:0] res_bits; // Operating resolution in bits.
	logic [2:0] shift; // Applied scale as a right shift.

	// Scaler drives, encoder output reads.
	modport producer(output target, res_bits, shift);
	modport consumer(input target, res_bits, shift);
endinterface

`default_nettype wire

// ==== verilog/sim_scaler.sv ====
// Picks the quantised scale and forms the count target of the output.
// Assumes configuration inputs come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none

module sim_scaler (
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] src,
	input wire logic [15:0] numer,
	input wire logic [1:0] lines,
	quad_target_if.producer tgt
);
	// ------------------------------------------------------------
	// Scale selection.
	// ------------------------------------------------------------
	wire [3:0] bits_w;
	wire [2:0] fine_w;
	wire [2:0] shift_w;
	wire [15:0] scaled_w;
	wire [15:0] target_w;

	// Resolution grows by two bits per lines step.
	assign bits_w = resolver_pkg::RES_BASE + {1'b0, lines, 1'b0};
	// Fine power-of-two step at full resolution.
	assign fine_w = (numer <= resolver_pkg::NUMER_T32) ? 3'h5 :
		(numer <= resolver_pkg::NUMER_T16) ? 3'h4 :
		(numer <= resolver_pkg::NUMER_T8) ? 3'h3 :
		(numer <= resolver_pkg::NUMER_T4) ? 3'h2 : 3'h1;
	// Coarser resolutions clamp the scale; large values give unity.
	assign shift_w = (numer > resolver_pkg::NUMER_T2) ? 3'h0 :
		(lines == 2'h0) ? 3'h1 :
		(lines == 2'h1 && fine_w > 3'h3) ? 3'h3 : fine_w;
	// Source times scale, then reduced to lines times four counts.
	assign scaled_w = src >> shift_w;
	assign target_w = scaled_w >>
		(resolver_pkg::POS_BITS - {1'b0, bits_w});

	// Registered so the output stage sees stable data.
	always_ff @(posedge clk) begin
		if (srst) begin
			tgt.target <= 16'h0000;
			tgt.res_bits <= resolver_pkg::RES_BASE;
			tgt.shift <= 3'h0;
		end else begin
			tgt.target <= target_w;
			tgt.res_bits <= bits_w;
			tgt.shift <= shift_w;
		end
	end

	a_scale_unity: assert property (
		@(posedge clk) disable iff (srst)
		numer > resolver_pkg::NUMER_T2 |=> tgt.shift == 3'h0)
		else $error("Scale is not unity above one half.");
	a_scale_coarse: assert property (
		@(posedge clk) disable iff (srst)
		(lines == 2'h0 && numer <= resolver_pkg::NUMER_T2) |=>
		tgt.shift == 3'h1)
		else $error("Coarse resolution scale is not one half.");
	// The smallest numerators reach the finest step only at full resolution.
	a_scale_fine: assert property (
		@(posedge clk) disable iff (srst)
		(lines == 2'h2 && numer <= resolver_pkg::NUMER_T32) |=>
		tgt.shift == 3'h5)
		else $error("Finest scale is not one thirty-second.");
endmodule

`default_nettype wire

// ==== verilog/quad_output.sv ====
// Steps a quadrature pair one count at a time toward the target count.
// Assumes the target moves less than half a revolution between steps.
`timescale 1ns/100ps
`default_nettype none

module quad_output #(
	parameter int STEP_CYCLES = resolver_pkg::EDGE_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	quad_target_if.consumer tgt,
	output logic phase_a,
	output logic phase_b
);
	typedef enum logic [1:0] {
		Q00 = 2'b00, Q01 = 2'b01, Q11 = 2'b11, Q10 = 2'b10
	} quad_t;

	quad_t state_reg, state_next; // Phase pair, B in bit 0.
	logic [15:0] count_reg; // Count already sent out.
	logic [7:0] gap_reg; // Cycles until the next edge may come.

	// ------------------------------------------------------------
	// Direction from the wrapped distance to the target.
	// ------------------------------------------------------------
	wire [15:0] mask_w;
	wire [15:0] dist_w;
	wire [15:0] aligned_w;
	wire fwd_w;
	wire rev_w;
	wire step_w;

	assign mask_w = (16'h0001 << tgt.res_bits) - 16'h0001;
	assign dist_w = tgt.target - count_reg;
	assign aligned_w = dist_w <<
		(resolver_pkg::POS_BITS - {1'b0, tgt.res_bits});
	assign fwd_w = aligned_w != 16'h0000 && !aligned_w[15];
	assign rev_w = aligned_w[15];
	assign step_w = (gap_reg == 8'h00) && (fwd_w || rev_w);

	// Gray sequence; A leads B when counting forward.
	always_comb begin
		state_next = state_reg;
		if (step_w) begin
			unique case (state_reg)
				Q00: state_next = fwd_w ? Q10 : Q01;
				Q10: state_next = fwd_w ? Q11 : Q00;
				Q11: state_next = fwd_w ? Q01 : Q10;
				Q01: state_next = fwd_w ? Q00 : Q11;
			endcase
		end
	end

	// One count per edge of either phase.
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= Q00;
			count_reg <= 16'h0000;
			gap_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (step_w) begin
				count_reg <= (fwd_w ? count_reg + 16'h0001 :
					count_reg - 16'h0001) & mask_w;
				gap_reg <= 8'(STEP_CYCLES - 1);
			end else if (gap_reg != 8'h00) begin
				gap_reg <= gap_reg - 8'h01;
			end
		end
	end

	assign phase_a = state_reg[1];
	assign phase_b = state_reg[0];

	a_quad_gray: assert property (
		@(posedge clk) disable iff (srst)
		!(phase_a != $past(phase_a) && phase_b != $past(phase_b)))
		else $error("Both phases changed together.");
	a_quad_spacing: assert property (
		@(posedge clk) disable iff (srst)
		$changed(state_reg) |=> $stable(state_reg))
		else $error("Edges came back to back.");
endmodule

`default_nettype wire

// ==== testbench/resolver_model.sv ====
// Behavioural resolver transducer on the far side of the block.
// Assumes the bench commands angle, speed and wire state on CLK.
`timescale 1ns/100ps
`default_nettype none

module resolver_model #(
	parameter int POLES = 2, // Transducer pole count.
	parameter int MOTOR_POLES = 2 // Pole count of the measured motor.
) (
	input wire logic clk,
	input wire logic exc_high,
	input wire logic [15:0] angle_cmd,
	input wire logic [19:0] speed_cmd,
	input wire logic broken,
	output logic [15:0] pos,
	output logic [19:0] speed,
	output logic fault
);
	// --------------------------------------------------
	// Rotor and windings
	// --------------------------------------------------
	// A multi-pole unit is only fitted to a motor of equal poles.
	localparam bit POLES_MATCH =
		(POLES == 2) || (POLES == MOTOR_POLES);

	// Powered up at rest with healthy windings.
	initial begin
		pos = 16'h0000;
		speed = 20'h00000;
		fault = 1'b0;
	end

	// The rotor slews one count per clock, so counts arrive spread out.
	// A broken winding shows as a fault level whatever the excitation.
	always @(posedge clk) begin
		if (pos != angle_cmd) begin
			pos <= (angle_cmd > pos) ? pos + 16'h0001 : pos - 16'h0001;
		end
		speed <= speed_cmd;
		fault <= broken && POLES_MATCH;
	end
endmodule

`default_nettype wire

// ==== testbench/tb_resolver_feedback_encoder_sim.sv ====
// Self-checking bench for the resolver feedback block.
// Assumes the design package and interface are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_resolver_feedback_encoder_sim;
	// --------------------------------------------------
	// Signals and expected setup rows
	// --------------------------------------------------
	typedef struct packed {
		logic [5:0] cfg;
		logic [15:0] numer;
		logic [15:0] info;
		logic [19:0] limit;
		logic exc;
	} row_t;
	// Each row: setup, numerator, info word, ceiling, excitation level.
	localparam row_t ROWS [0:10] = '{
		'{6'h24, 16'h0138, 16'h510e, 20'h080e8, 1'b1},
		'{6'h24, 16'h0139, 16'h410e, 20'h080e8, 1'b1},
		'{6'h24, 16'h0271, 16'h410e, 20'h080e8, 1'b1},
		'{6'h24, 16'h04e2, 16'h310e, 20'h080e8, 1'b1},
		'{6'h24, 16'h04e3, 16'h210e, 20'h080e8, 1'b1},
		'{6'h24, 16'h1388, 16'h110e, 20'h080e8, 1'b1},
		'{6'h2b, 16'h0138, 16'h320c, 20'h101d0, 1'b0},
		'{6'h2b, 16'h09c5, 16'h120c, 20'h101d0, 1'b0},
		'{6'h30, 16'h1388, 16'h130a, 20'h2af80, 1'b1},
		'{6'h3c, 16'h1389, 16'h040e, 20'h0203a, 1'b1},
		'{6'h38, 16'h7530, 16'h040a, 20'h203a0, 1'b1}
	};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [5:0] addr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic waitreq;
	logic [15:0] pos;
	logic [15:0] src_value = 16'h0000;
	logic [15:0] src_id;
	logic [19:0] speed;
	logic fault;
	logic exc_high;
	logic trip;
	logic qa;
	logic qb;
	logic irq;
	logic [15:0] angle_cmd = 16'h0000;
	logic [19:0] speed_cmd = 20'h00000;
	logic broken = 1'b0;
	logic [31:0] r;
	logic [1:0] prev_q = 2'b00;
	logic gray_bad = 1'b0;
	int edges = 0;
	int failures = 0;
	int comparisons = 0;

	// Clock of 5 ns period.
	always #2.5 clk = ~clk;

	resolver_feedback_top #(.STEP_CYCLES(2)) dut (.CLK(clk), .SRST(srst),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .POS_IN(pos), .SRC_VALUE(src_value),
		.SRC_ID(src_id), .SPEED_MAG(speed), .WIRE_FAULT(fault),
		.EXC_HIGH(exc_high), .TRIP(trip), .QUAD_A(qa), .QUAD_B(qb),
		.IRQ(irq));

	resolver_model rsv (.clk(clk), .exc_high(exc_high),
		.angle_cmd(angle_cmd), .speed_cmd(speed_cmd), .broken(broken),
		.pos(pos), .speed(speed), .fault(fault));

	// Counts output steps mid-cycle and flags a two-phase jump.
	always @(negedge clk) begin
		if ({qa, qb} !== prev_q) edges++;
		if (({qa, qb} ^ prev_q) == 2'b11) gray_bad = 1'b1;
		prev_q = {qa, qb};
	end

	// --------------------------------------------------
	// Shared tasks
	// --------------------------------------------------
	// Prints the counts and the verdict, then stops.
	task close_out;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Compares one value against its expectation.
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One bus cycle, held until waitrequest is low at a rising edge.
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		logic done;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		n = 0;
		done = 1'b0;
		while (!done) begin
			@(posedge clk);
			done = (waitreq === 1'b0);
			n++;
			if (!done && n > 40) begin
				failures++;
				close_out();
			end
		end
		// Read data is taken at the answering edge, then all is released.
		r = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	// Reads a register and compares it.
	task rdchk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(r, exp);
	endtask

	// Waits, bounded, until the output has made n steps.
	task wait_edges(input int n);
		int k;
		k = 0;
		while (edges < n && k < 400) begin
			@(posedge clk);
			k++;
		end
		if (edges < n) begin
			failures++;
			close_out();
		end
	endtask

	// --------------------------------------------------
	// Main sequence
	// --------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		check(rdata, 32'h0);
		check({waitreq, exc_high, trip, irq, qa, qb}, 6'h30);
		check(src_id, 16'h0f05);
		@(posedge clk);
		rdchk(resolver_pkg::ADDR_CONFIG, 32'h24);
		rdchk(resolver_pkg::ADDR_NUMER, 32'h2710);
		rdchk(resolver_pkg::ADDR_INFO, 32'h010e);
		rdchk(resolver_pkg::ADDR_LIMIT, 32'h080e8);
		rdchk(resolver_pkg::ADDR_ENABLE, 32'h0);
		// Every lines and pole code, and each scale threshold.
		foreach (ROWS[i]) begin
			bus(1'b1, resolver_pkg::ADDR_CONFIG, 32'(ROWS[i].cfg));
			bus(1'b1, resolver_pkg::ADDR_NUMER, 32'(ROWS[i].numer));
			rdchk(resolver_pkg::ADDR_CONFIG, 32'(ROWS[i].cfg));
			rdchk(resolver_pkg::ADDR_INFO, 32'(ROWS[i].info));
			rdchk(resolver_pkg::ADDR_LIMIT, 32'(ROWS[i].limit));
			check(exc_high, ROWS[i].exc);
		end
		// Illegal settings are refused and flagged.
		bus(1'b1, resolver_pkg::ADDR_CONFIG, 32'h26);
		rdchk(resolver_pkg::ADDR_CONFIG, 32'h38);
		bus(1'b1, resolver_pkg::ADDR_SOURCE, 32'h1534);
		rdchk(resolver_pkg::ADDR_SOURCE, 32'h0f05);
		bus(1'b1, resolver_pkg::ADDR_NUMER, 32'h7531);
		rdchk(resolver_pkg::ADDR_NUMER, 32'h7530);
		rdchk(resolver_pkg::ADDR_STATUS, 32'h4);
		bus(1'b1, 6'h20, 32'hffff);
		rdchk(6'h20, 32'h0);
		rdchk(resolver_pkg::ADDR_CLEAR, 32'h0);
		// Interrupt raised, masked and cleared.
		bus(1'b1, resolver_pkg::ADDR_ENABLE, 32'h4);
		check(irq, 1'b1);
		bus(1'b1, resolver_pkg::ADDR_ENABLE, 32'h3);
		check(irq, 1'b0);
		bus(1'b1, resolver_pkg::ADDR_CLEAR, 32'h4);
		rdchk(resolver_pkg::ADDR_STATUS, 32'h0);
		// Source identifier at its limits.
		bus(1'b1, resolver_pkg::ADDR_SOURCE, 32'h1533);
		check(src_id, 16'h1533);
		bus(1'b1, resolver_pkg::ADDR_SOURCE, 32'h0000);
		check(src_id, 16'h0000);
		bus(1'b1, resolver_pkg::ADDR_SOURCE, 32'h0f05);
		bus(1'b1, resolver_pkg::ADDR_CONFIG, 32'h24);
		// Speed at the ceiling, then just above it.
		speed_cmd <= 20'h080e8;
		repeat (6) @(posedge clk);
		check(irq, 1'b0);
		speed_cmd <= 20'h080e9;
		repeat (6) @(posedge clk);
		check(irq, 1'b1);
		speed_cmd <= 20'h0;
		bus(1'b1, resolver_pkg::ADDR_CLEAR, 32'h7);
		// Broken wire trips only while detection is on.
		broken <= 1'b1;
		repeat (6) @(posedge clk);
		check(trip, 1'b1);
		broken <= 1'b0;
		// Let the fault drain through the synchroniser before the clear.
		repeat (4) @(posedge clk);
		bus(1'b1, resolver_pkg::ADDR_CLEAR, 32'h1);
		bus(1'b1, resolver_pkg::ADDR_CONFIG, 32'h04);
		broken <= 1'b1;
		repeat (8) @(posedge clk);
		check(trip, 1'b0);
		broken <= 1'b0;
		bus(1'b1, resolver_pkg::ADDR_NUMER, 32'h2710);
		// Forward three output counts, then back.
		angle_cmd <= 16'h000c;
		wait_edges(1);
		check({qa, qb}, 2'b10);
		wait_edges(3);
		repeat (30) @(posedge clk);
		check(edges, 3);
		check({qa, qb}, 2'b01);
		angle_cmd <= 16'h0000;
		wait_edges(6);
		repeat (30) @(posedge clk);
		check({qa, qb}, 2'b00);
		// Alternate source, then half scale.
		src_value <= 16'h0010;
		bus(1'b1, resolver_pkg::ADDR_SOURCE, 32'h0105);
		wait_edges(10);
		repeat (30) @(posedge clk);
		check(edges, 10);
		bus(1'b1, resolver_pkg::ADDR_NUMER, 32'h1388);
		wait_edges(12);
		repeat (30) @(posedge clk);
		check(edges, 12);
		check({qa, qb}, 2'b11);
		check(gray_bad, 1'b0);
		// A reset in mid-run brings back the defaults and parks the phases.
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		check({exc_high, trip, irq, qa, qb}, 5'h10);
		rdchk(resolver_pkg::ADDR_CONFIG, 32'h24);
		rdchk(resolver_pkg::ADDR_SOURCE, 32'h0f05);
		rdchk(resolver_pkg::ADDR_NUMER, 32'h2710);
		close_out();
	end

	// Cuts the run short if anything hangs.
	initial begin
		repeat (50000) @(posedge clk);
		failures++;
		close_out();
	end
endmodule

`default_nettype wire
